// file: rcotc_defines.vh
// Register offsets, field positions and reset values of the RC oscillation touch counter.
`ifndef RCOTC_DEFINES_VH
`define RCOTC_DEFINES_VH

// ----------------------------------------------------------------------------
// Register byte addresses on the APB bus.
// ----------------------------------------------------------------------------
`define RCOTC_ADDR_MODE 8'h00
`define RCOTC_ADDR_CTRL 8'h04
`define RCOTC_ADDR_TA_LO 8'h08
`define RCOTC_ADDR_TA_HI 8'h0c
`define RCOTC_ADDR_TB_LO 8'h10
`define RCOTC_ADDR_TB_HI 8'h14
`define RCOTC_ADDR_IRQ_STAT 8'h18
`define RCOTC_ADDR_IRQ_MASK 8'h1c

// ----------------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------------
`define RCOTC_MODE_OVSEL_BIT 0
`define RCOTC_MODE_EN_BIT 1
`define RCOTC_CTRL_RUN_BIT 4
`define RCOTC_CTRL_CSEL_LSB 5
`define RCOTC_CTRL_CSEL_MSB 7
`define RCOTC_IRQ_FLAG_BIT 5

// ----------------------------------------------------------------------------
// Encodings and reset values.
// ----------------------------------------------------------------------------
`define RCOTC_CSEL_DIV4 3'h1
`define RCOTC_PRESCALE_LAST 2'h3
`define RCOTC_MODE_RESET 2'h0
`define RCOTC_CSEL_RESET 3'h0
`define RCOTC_MASK_RESET 1'h0

`endif

// file: rcotc_dummy.v
// Intentionally empty.

// file: rcotc_edge.v
// Rising-edge detector for the external RC oscillator input.
`timescale 1ns/1ns

module rcotc_edge
(
    input wire clk,
    input wire rst_n,
    input wire clk_en,
    input wire sig_in,
    output reg rise
);

    // Previous sample of the oscillator input.
    reg sig_prev;

    // ------------------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------------------
    // A rise is a one-cycle pulse one cycle after the input goes high.
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sig_prev <= 1'b0;
            rise <= 1'b0;
        end
        else if (clk_en)
        begin
            sig_prev <= sig_in;
            rise <= sig_in & ~sig_prev;
        end
    end

endmodule // rcotc_edge

// file: rcotc_rc_osc.sv
// Behavioural model of the external RC oscillator on a touch pad.
`timescale 1ns/1ns

module rcotc_rc_osc
(
    input wire pclk,
    input wire presetn,
    input wire en,
    input wire [7:0] half,
    output reg rc_out
);
    // Cycles spent in the current half period.
    reg [7:0] cnt;

    // Toggles every half cycles while enabled; stands low when the pad is idle.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt <= 8'h00;
            rc_out <= 1'b0;
        end
        else if (!en)
        begin
            cnt <= 8'h00;
            rc_out <= 1'b0;
        end
        else if (cnt == half - 8'h01)
        begin
            cnt <= 8'h00;
            rc_out <= ~rc_out;
        end
        else
        begin
            cnt <= cnt + 8'h01;
        end
    end
endmodule // rcotc_rc_osc

// file: rcotc_timer16.v
// Up-counter with buffered low-byte write and latched low-byte read.
`timescale 1ns/1ns

module rcotc_timer16
#(
    parameter WIDTH = 16
)
(
    input wire clk,
    input wire rst_n,
    input wire clk_en,
    input wire wr_lo,
    input wire wr_hi,
    input wire rd_hi,
    input wire [WIDTH/2-1:0] wdata,
    input wire inc,
    output wire [WIDTH/2-1:0] hi_byte,
    output wire [WIDTH/2-1:0] lo_latched,
    output wire ovf
);

    // Holding buffer for a written low byte.
    reg [WIDTH/2-1:0] lo_buf;
    // The running count.
    reg [WIDTH-1:0] count;
    // Low byte captured by the last high-byte read.
    reg [WIDTH/2-1:0] lo_latch;

    // Overflow is the increment that leaves the all-ones value.
    assign ovf = inc & (&count);
    assign hi_byte = count[WIDTH-1:WIDTH/2];
    assign lo_latched = lo_latch;

    // ------------------------------------------------------------------------
    // Count and byte access
    // ------------------------------------------------------------------------
    // A low write only fills the buffer; a high write loads both halves.
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lo_buf <= {(WIDTH/2){1'b0}};
            count <= {WIDTH{1'b0}};
            lo_latch <= {(WIDTH/2){1'b0}};
        end
        else if (clk_en)
        begin
            if (wr_lo)
            begin
                lo_buf <= wdata;
            end
            if (wr_hi)
            begin
                count <= {wdata, lo_buf};
            end
            else if (inc)
            begin
                count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
            end
            if (rd_hi)
            begin
                lo_latch <= count[WIDTH/2-1:0];
            end
        end
    end

endmodule // rcotc_timer16

// file: rcotc_top.v
// APB top of the RC oscillation touch counter with its two timers and interrupt.
`timescale 1ns/1ns
`include "rcotc_defines.vh"

module rcotc_top
(
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire rc_osc_in,
    output reg irq
);

    // ------------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------------

    // True for any of the four timer byte addresses.
    function is_timer;
        input [7:0] addr;
        begin
            is_timer = (addr == `RCOTC_ADDR_TA_LO) || (addr == `RCOTC_ADDR_TA_HI) ||
                       (addr == `RCOTC_ADDR_TB_LO) || (addr == `RCOTC_ADDR_TB_HI);
        end
    endfunction

    // True for any mapped address.
    function is_mapped;
        input [7:0] addr;
        begin
            is_mapped = is_timer(addr) || (addr == `RCOTC_ADDR_MODE) ||
                        (addr == `RCOTC_ADDR_CTRL) || (addr == `RCOTC_ADDR_IRQ_STAT) ||
                        (addr == `RCOTC_ADDR_IRQ_MASK);
        end
    endfunction

    // ------------------------------------------------------------------------
    // Control and status state
    // ------------------------------------------------------------------------

    // Overflow source select: zero picks timer A, one picks timer B.
    reg overflow_source_select;
    // Converter enable.
    reg converter_enable;
    // Clock select field of the count control register.
    reg [2:0] ref_clock_select;
    // Run bit of the count control register.
    reg count_run_bit;
    // Sticky interrupt request flag.
    reg converter_irq_flag;
    // Interrupt mask bit, one lets the flag reach the output.
    reg irq_mask;
    // Prescaler for the quarter-rate reference clock.
    reg [1:0] prescale;

    // ------------------------------------------------------------------------
    // Bus access qualification
    // ------------------------------------------------------------------------

    // First access cycle of a transfer; the answer follows one edge later.
    wire access;
    // Access to a timer byte while the run bit blocks it.
    wire blocked;
    // Write and read strobes, one cycle each.
    wire do_wr;
    wire do_rd;

    assign access = psel & penable & ~pready;
    assign blocked = is_timer(paddr) & count_run_bit;
    assign do_wr = access & pwrite & ~blocked;
    assign do_rd = access & ~pwrite & ~blocked;

    // ------------------------------------------------------------------------
    // Counting qualification
    // ------------------------------------------------------------------------

    // Counting needs both the unit enable and the run bit.
    wire counting;
    // Quarter-rate selected for the reference timer.
    wire sel_div4;
    // Increment strobes of both timers.
    wire inc_a;
    wire inc_b;
    // One-cycle rise of the oscillator input.
    wire rc_rise;
    // Overflow strobes of both timers.
    wire ovf_a;
    wire ovf_b;
    // Either timer overflowed.
    wire ovf_any;
    // The overflow that feeds the interrupt flag.
    wire ovf_sel;

    assign counting = converter_enable & count_run_bit;
    assign sel_div4 = (ref_clock_select == `RCOTC_CSEL_DIV4);
    assign inc_a = counting & (~sel_div4 | (prescale == `RCOTC_PRESCALE_LAST));
    assign inc_b = counting & rc_rise;
    assign ovf_any = ovf_a | ovf_b;
    assign ovf_sel = overflow_source_select ? ovf_b : ovf_a;

    // ------------------------------------------------------------------------
    // Timer write and read strobes
    // ------------------------------------------------------------------------

    wire wr_a_lo;
    wire wr_a_hi;
    wire wr_b_lo;
    wire wr_b_hi;
    wire rd_a_hi;
    wire rd_b_hi;

    assign wr_a_lo = do_wr & (paddr == `RCOTC_ADDR_TA_LO);
    assign wr_a_hi = do_wr & (paddr == `RCOTC_ADDR_TA_HI);
    assign wr_b_lo = do_wr & (paddr == `RCOTC_ADDR_TB_LO);
    assign wr_b_hi = do_wr & (paddr == `RCOTC_ADDR_TB_HI);
    assign rd_a_hi = do_rd & (paddr == `RCOTC_ADDR_TA_HI);
    assign rd_b_hi = do_rd & (paddr == `RCOTC_ADDR_TB_HI);

    // Byte views of both timers.
    wire [7:0] a_hi;
    wire [7:0] a_lo;
    wire [7:0] b_hi;
    wire [7:0] b_lo;

    // ------------------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------------------

    // Edge detector on the touch pad oscillator.
    rcotc_edge u_edge
    (
        .clk(pclk),
        .rst_n(presetn),
        .clk_en(clk_en),
        .sig_in(rc_osc_in),
        .rise(rc_rise)
    );

    // Reference timer A.
    rcotc_timer16 #(.WIDTH(16)) u_timer_a
    (
        .clk(pclk),
        .rst_n(presetn),
        .clk_en(clk_en),
        .wr_lo(wr_a_lo),
        .wr_hi(wr_a_hi),
        .rd_hi(rd_a_hi),
        .wdata(pwdata[7:0]),
        .inc(inc_a),
        .hi_byte(a_hi),
        .lo_latched(a_lo),
        .ovf(ovf_a)
    );

    // Measurement timer B.
    rcotc_timer16 #(.WIDTH(16)) u_timer_b
    (
        .clk(pclk),
        .rst_n(presetn),
        .clk_en(clk_en),
        .wr_lo(wr_b_lo),
        .wr_hi(wr_b_hi),
        .rd_hi(rd_b_hi),
        .wdata(pwdata[7:0]),
        .inc(inc_b),
        .hi_byte(b_hi),
        .lo_latched(b_lo),
        .ovf(ovf_b)
    );

    // ------------------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------------------
    // Free count while counting; restarts from zero at each stop so that
    // every run begins with a full quarter period.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prescale <= 2'h0;
        end
        else if (clk_en)
        begin
            if (counting)
            begin
                prescale <= prescale + 2'h1;
            end
            else
            begin
                prescale <= 2'h0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Configuration registers and run bit
    // ------------------------------------------------------------------------
    // An overflow clears the run bit and wins over a write in the same cycle.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            overflow_source_select <= 1'b0;
            converter_enable <= 1'b0;
            ref_clock_select <= `RCOTC_CSEL_RESET;
            count_run_bit <= 1'b0;
            irq_mask <= `RCOTC_MASK_RESET;
        end
        else if (clk_en)
        begin
            if (do_wr && (paddr == `RCOTC_ADDR_MODE))
            begin
                overflow_source_select <= pwdata[`RCOTC_MODE_OVSEL_BIT];
                converter_enable <= pwdata[`RCOTC_MODE_EN_BIT];
            end
            if (do_wr && (paddr == `RCOTC_ADDR_IRQ_MASK))
            begin
                irq_mask <= pwdata[`RCOTC_IRQ_FLAG_BIT];
            end
            if (ovf_any)
            begin
                count_run_bit <= 1'b0;
            end
            else if (do_wr && (paddr == `RCOTC_ADDR_CTRL))
            begin
                ref_clock_select <= pwdata[`RCOTC_CTRL_CSEL_MSB:`RCOTC_CTRL_CSEL_LSB];
                count_run_bit <= pwdata[`RCOTC_CTRL_RUN_BIT];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Interrupt flag
    // ------------------------------------------------------------------------
    // Sticky until a one is written to it; a new overflow wins over the clear.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            converter_irq_flag <= 1'b0;
        end
        else if (clk_en)
        begin
            if (ovf_sel)
            begin
                converter_irq_flag <= 1'b1;
            end
            else if (do_wr && (paddr == `RCOTC_ADDR_IRQ_STAT) && pwdata[`RCOTC_IRQ_FLAG_BIT])
            begin
                converter_irq_flag <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Interrupt output
    // ------------------------------------------------------------------------
    // Registered level, high one cycle after an unmasked flag is set.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq <= 1'b0;
        end
        else if (clk_en)
        begin
            irq <= converter_irq_flag & irq_mask;
        end
    end

    // ------------------------------------------------------------------------
    // Read data mux
    // ------------------------------------------------------------------------
    // Blocked and unmapped reads return zero.
    reg [31:0] next_prdata;

    always @*
    begin
        next_prdata = 32'h0000_0000;
        if (!blocked)
        begin
            case (paddr)
                `RCOTC_ADDR_MODE:
                begin
                    next_prdata = {30'h0, converter_enable, overflow_source_select};
                end
                `RCOTC_ADDR_CTRL:
                begin
                    next_prdata = {24'h0, ref_clock_select, count_run_bit, 4'h0};
                end
                `RCOTC_ADDR_TA_LO:
                begin
                    next_prdata = {24'h0, a_lo};
                end
                `RCOTC_ADDR_TA_HI:
                begin
                    next_prdata = {24'h0, a_hi};
                end
                `RCOTC_ADDR_TB_LO:
                begin
                    next_prdata = {24'h0, b_lo};
                end
                `RCOTC_ADDR_TB_HI:
                begin
                    next_prdata = {24'h0, b_hi};
                end
                `RCOTC_ADDR_IRQ_STAT:
                begin
                    next_prdata = {26'h0, converter_irq_flag, 5'h0};
                end
                `RCOTC_ADDR_IRQ_MASK:
                begin
                    next_prdata = {26'h0, irq_mask, 5'h0};
                end
                default:
                begin
                    next_prdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // APB answer
    // ------------------------------------------------------------------------
    // One wait state: pready rises one edge after the access phase begins
    // and falls at the next edge. Unmapped or blocked accesses raise pslverr.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else if (clk_en)
        begin
            pready <= access;
            if (access)
            begin
                prdata <= pwrite ? 32'h0000_0000 : next_prdata;
                pslverr <= blocked | ~is_mapped(paddr);
            end
            else
            begin
                pslverr <= 1'b0;
            end
        end
    end

endmodule // rcotc_top

// file: rcotc_top_props.sv
// Checker for the APB answer and the interrupt output of the touch counter.
`timescale 1ns/1ns
`include "rcotc_defines.vh"

module rcotc_props
(
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire rc_osc_in,
    input wire irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // High on the edge where the slave takes a request.
    wire take = psel && penable && !pready && clk_en;
    // Access phase of a transfer, kept as one signal for the history check.
    wire acc_phase = psel && penable;
    // A taken write to the status or mask register, the only accesses that may lower irq.
    wire irq_wr = take && pwrite && (paddr == `RCOTC_ADDR_IRQ_STAT || paddr == `RCOTC_ADDR_IRQ_MASK);

    ready_pulse_a: assert property (pready |=> !pready) else $error("pready held too long");
    ready_time_a: assert property (take |=> pready) else $error("pready not one cycle after take");
    ready_cause_a: assert property (pready |-> $past(acc_phase)) else $error("pready without access");
    err_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
    unmapped_err_a: assert property ((pready && paddr > 8'h1c) |-> pslverr) else $error("unmapped not refused");
    err_zero_a: assert property ((pready && (pslverr || pwrite)) |-> prdata == 32'h0)
        else $error("refused or write gave data");
    irq_clear_a: assert property ($fell(irq) |-> $past(irq_wr, 2)) else $error("irq fell unasked");
    freeze_hold_a: assert property (!clk_en |=> $stable({pready, pslverr, prdata, irq}))
        else $error("outputs moved while frozen");

    cover property ($rose(irq));
    cover property (pready && pslverr);
    cover property ($rose(rc_osc_in));
endmodule // rcotc_props

bind rcotc_top rcotc_props u_props (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rc_osc_in(rc_osc_in), .irq(irq));

// file: testbench.sv
// Self-checking bench of the touch counter with an RC oscillator model.
`timescale 1ns/1ns
`include "rcotc_defines.vh"

module testbench;
    reg pclk = 1'b0;
    reg presetn = 1'b0;
    reg clk_en = 1'b1;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [7:0] paddr = 8'h00;
    reg [31:0] pwdata = 32'h0;
    reg rc_en = 1'b0;
    wire [31:0] prdata;
    wire pready, pslverr, irq, rc_osc;
    integer miscompares = 0;
    integer checks = 0;
    integer n, n1, i;
    reg [31:0] rd, v;
    reg er;
    typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e; logic ee;} rcotc_row_t;
    rcotc_row_t rows [0:15];

    always #10 pclk = ~pclk;

    rcotc_top dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rc_osc_in(rc_osc), .irq(irq));
    rcotc_rc_osc osc (.pclk(pclk), .presetn(presetn), .en(rc_en), .half(8'h03), .rc_out(rc_osc));

    // Prints the verdict and ends the run.
    task test_done;
        if (miscompares == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task chk(input string nm, input [31:0] e, input [31:0] g);
        checks = checks + 1;
        if (g !== e)
        begin
            $display("[FAIL] %0s expected %h seen %h", nm, e, g);
            miscompares = miscompares + 1;
        end
    endtask

    // One APB transfer; waits for pready under a bound.
    task apb(input w, input [7:0] a, input [31:0] d);
        integer k;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && k < 20)
        begin
            @(posedge pclk);
            k = k + 1;
        end
        // A wait that used up its bound is a mismatch and ends the run.
        if (pready !== 1'b1)
        begin
            $display("[FAIL] pready expected 1 seen %b", pready);
            miscompares = miscompares + 1;
            test_done;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rdx(input [7:0] a, input [31:0] e, input ee, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
        chk("read error", ee, er);
    endtask

    task wrx(input [7:0] a, input [31:0] d, input ee);
        apb(1'b1, a, d);
        chk("write error", ee, er);
    endtask

    task wait_irq;
        n = 0;
        while (irq !== 1'b1 && n < 1000)
        begin
            @(posedge pclk);
            n = n + 1;
        end
        // An interrupt that never came is a mismatch and ends the run.
        if (irq !== 1'b1)
        begin
            $display("[FAIL] irq expected 1 seen %b", irq);
            miscompares = miscompares + 1;
            test_done;
        end
    endtask

    task do_reset;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
    endtask

    initial
    begin
        rows = '{'{1'h1, `RCOTC_ADDR_MODE, 32'h2, 32'h0, 1'h0}, '{1'h0, `RCOTC_ADDR_MODE, 32'h0, 32'h2, 1'h0},
            '{1'h1, `RCOTC_ADDR_CTRL, 32'he0, 32'h0, 1'h0}, '{1'h0, `RCOTC_ADDR_CTRL, 32'h0, 32'he0, 1'h0},
            '{1'h1, `RCOTC_ADDR_CTRL, 32'h0, 32'h0, 1'h0}, '{1'h1, `RCOTC_ADDR_IRQ_MASK, 32'h20, 32'h0, 1'h0},
            '{1'h0, `RCOTC_ADDR_IRQ_MASK, 32'h0, 32'h20, 1'h0}, '{1'h1, `RCOTC_ADDR_TA_LO, 32'h34, 32'h0, 1'h0},
            '{1'h0, `RCOTC_ADDR_TA_HI, 32'h0, 32'h0, 1'h0}, '{1'h1, `RCOTC_ADDR_TA_HI, 32'h12, 32'h0, 1'h0},
            '{1'h0, `RCOTC_ADDR_TA_HI, 32'h0, 32'h12, 1'h0}, '{1'h0, `RCOTC_ADDR_TA_LO, 32'h0, 32'h34, 1'h0},
            '{1'h1, 8'h20, 32'h5, 32'h0, 1'h1}, '{1'h0, 8'h20, 32'h0, 32'h0, 1'h1},
            '{1'h1, `RCOTC_ADDR_TB_LO, 32'h0, 32'h0, 1'h0}, '{1'h1, `RCOTC_ADDR_TB_HI, 32'h0, 32'h0, 1'h0}};
        do_reset;
        // Ordinary register traffic from the table.
        for (i = 0; i < 16; i = i + 1)
        begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            chk("row data", rows[i].e, rd);
            chk("row error", rows[i].ee, er);
        end
        // Timer A overflow on the system clock, then on the quarter clock.
        wrx(`RCOTC_ADDR_TA_LO, 32'hf0, 1'b0);
        wrx(`RCOTC_ADDR_TA_HI, 32'hff, 1'b0);
        apb(1'b1, `RCOTC_ADDR_CTRL, 32'h10);
        wait_irq;
        n1 = n;
        rdx(`RCOTC_ADDR_CTRL, 32'h0, 1'b0, "run cleared");
        rdx(`RCOTC_ADDR_IRQ_STAT, 32'h20, 1'b0, "flag set");
        rdx(`RCOTC_ADDR_TA_HI, 32'h0, 1'b0, "a wrap hi");
        rdx(`RCOTC_ADDR_TA_LO, 32'h0, 1'b0, "a wrap lo");
        rdx(`RCOTC_ADDR_TB_HI, 32'h0, 1'b0, "b idle");
        repeat (5) @(posedge pclk);
        chk("irq held", 1'b1, irq);
        wrx(`RCOTC_ADDR_IRQ_STAT, 32'h20, 1'b0);
        rdx(`RCOTC_ADDR_IRQ_STAT, 32'h0, 1'b0, "flag cleared");
        chk("irq cleared", 1'b0, irq);
        wrx(`RCOTC_ADDR_TA_LO, 32'hf0, 1'b0);
        wrx(`RCOTC_ADDR_TA_HI, 32'hff, 1'b0);
        apb(1'b1, `RCOTC_ADDR_CTRL, 32'h30);
        wait_irq;
        chk("quarter clock", n1 + 48, n);
        wrx(`RCOTC_ADDR_IRQ_STAT, 32'h20, 1'b0);
        // Timer B overflow from the oscillator, masked, with a freeze in mid-run.
        wrx(`RCOTC_ADDR_TB_LO, 32'hfd, 1'b0);
        wrx(`RCOTC_ADDR_TB_HI, 32'hff, 1'b0);
        wrx(`RCOTC_ADDR_TA_LO, 32'h0, 1'b0);
        wrx(`RCOTC_ADDR_TA_HI, 32'h0, 1'b0);
        wrx(`RCOTC_ADDR_MODE, 32'h3, 1'b0);
        wrx(`RCOTC_ADDR_IRQ_MASK, 32'h0, 1'b0);
        apb(1'b1, `RCOTC_ADDR_CTRL, 32'h10);
        rc_en <= 1'b1;
        @(posedge pclk);
        clk_en <= 1'b0;
        repeat (30) @(posedge pclk);
        clk_en <= 1'b1;
        rdx(`RCOTC_ADDR_IRQ_STAT, 32'h0, 1'b0, "frozen flag");
        rdx(`RCOTC_ADDR_TB_HI, 32'h0, 1'b1, "blocked read");
        wrx(`RCOTC_ADDR_TA_HI, 32'h55, 1'b1);
        i = 0;
        rd = 32'h0;
        while (rd !== 32'h20 && i < 40)
        begin
            apb(1'b0, `RCOTC_ADDR_IRQ_STAT, 32'h0);
            i = i + 1;
        end
        chk("b flag", 32'h20, rd);
        rdx(`RCOTC_ADDR_CTRL, 32'h0, 1'b0, "b run cleared");
        rdx(`RCOTC_ADDR_TB_HI, 32'h0, 1'b0, "b wrap hi");
        rdx(`RCOTC_ADDR_TB_LO, 32'h0, 1'b0, "b wrap lo");
        rdx(`RCOTC_ADDR_TA_HI, 32'h0, 1'b0, "a not written");
        apb(1'b0, `RCOTC_ADDR_TA_LO, 32'h0);
        v = rd;
        repeat (10) @(posedge pclk);
        rdx(`RCOTC_ADDR_TA_HI, 32'h0, 1'b0, "a stopped hi");
        rdx(`RCOTC_ADDR_TA_LO, v, 1'b0, "a stopped lo");
        chk("irq masked", 1'b0, irq);
        wrx(`RCOTC_ADDR_IRQ_MASK, 32'h20, 1'b0);
        repeat (2) @(posedge pclk);
        chk("irq unmasked", 1'b1, irq);
        wrx(`RCOTC_ADDR_IRQ_STAT, 32'h20, 1'b0);
        rc_en <= 1'b0;
        // Run with the converter disabled, then a reset in mid-run.
        wrx(`RCOTC_ADDR_MODE, 32'h0, 1'b0);
        wrx(`RCOTC_ADDR_TA_LO, 32'hfe, 1'b0);
        wrx(`RCOTC_ADDR_TA_HI, 32'hff, 1'b0);
        apb(1'b1, `RCOTC_ADDR_CTRL, 32'h10);
        repeat (20) @(posedge pclk);
        rdx(`RCOTC_ADDR_CTRL, 32'h10, 1'b0, "idle run");
        rdx(`RCOTC_ADDR_IRQ_STAT, 32'h0, 1'b0, "idle flag");
        rdx(`RCOTC_ADDR_TA_HI, 32'h0, 1'b1, "idle blocked");
        do_reset;
        for (i = 0; i < 8; i = i + 1) rdx(8'(i * 4), 32'h0, 1'b0, "reset value");
        chk("reset irq", 1'b0, irq);
        test_done;
    end
endmodule // testbench
